// file: logic/spr_ctrl.sv
// Purpose: sleep mode selection, detector-off unlock and peripheral gating
// Assumes: apb slave, zero wait states, one clock
// Notes:   unmapped addresses read zero and answer with pslverr
//
// Chosen here: the APB interface to the registers.
`default_nettype none
module spr_ctrl (
  input  wire logic               pclk,              // system clock, 25 MHz
  input  wire logic               presetn,           // async reset, low
  input  wire logic               psel,              // apb select
  input  wire logic               penable,           // apb access phase
  input  wire logic               pwrite,            // apb direction
  input  wire logic [11:0]        paddr,             // apb byte address
  input  wire logic [31:0]        pwdata,            // apb write data
  output logic [31:0]             prdata,            // apb read data
  output logic                    pready,            // apb ready
  output logic                    pslverr,           // apb error
  input  wire logic [2:0]         prep_read,         // prepared-read selectors
  input  wire logic               sleep_req,         // sleep instruction pulse
  input  wire logic               wake,              // wake-up event level
  output spr_pkg::spr_clk_en_t    clk_en,            // clock enables
  output spr_pkg::spr_access_t    periph_access,     // register access allowed
  output logic                    comp_mux_allow,    // comparator may use mux
  output logic                    detector_disable,  // supply-drop detector off
  output logic                    sleeping,          // core asleep
  output logic [1:0]              sleep_mode         // active sleep mode
);

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0]           mcu;        // mcu_power_control storage
    logic [3:0]           gate;       // power_reduction bits 3:0
    logic [2:0]           win;        // unlock window cycles left
    logic [2:0]           eff_cnt;    // cycles until detector-off in effect
    logic [2:0]           hold_cnt;   // cycles until detector-off clears
    logic                 det_eff;    // detector-off in effect
    logic [31:0]          rdata;
    logic                 ready;
    logic                 err;
    spr_pkg::spr_clk_en_t clk;
    spr_pkg::spr_access_t acc;
    logic                 mux_ok;
    logic                 det_dis;
    logic                 slp;
    logic [1:0]           smode;
  } spr_state_t;

  spr_state_t s_reg;
  spr_state_t s_next;

  logic                  fsm_asleep;
  spr_pkg::spr_mode_t    fsm_mode;
  logic                  fsm_det_off;
  logic                  setup;
  logic                  wr_acc;
  logic                  rd_acc;

  // decrementing counter that stops at zero
  function automatic logic [2:0] dec_sat(input logic [2:0] v);
    dec_sat = (v == 3'h0) ? 3'h0 : v - 3'h1;
  endfunction

  // decode of a byte address to a register hit
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // sleep tracking
  spr_sleep_fsm u_sleep (
    .pclk       (pclk),
    .presetn    (presetn),
    .sleep_req  (sleep_req),
    .wake       (wake),
    .sleep_arm  (s_reg.mcu[spr_pkg::SLEEP_ARM_BIT]),
    .sleep_sel  (s_reg.mcu[spr_pkg::SEL_HI_BIT:spr_pkg::SEL_LO_BIT]),
    .det_active (s_reg.det_eff),
    .asleep     (fsm_asleep),
    .mode       (fsm_mode),
    .det_off    (fsm_det_off)
  );

  // answer in the first access cycle; pready registered from the setup cycle
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite && s_reg.ready;
  assign rd_acc = psel && penable && !pwrite && s_reg.ready;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic       wr_mcu;
    logic       wr_pr;
    logic [7:0] wd;
    logic       clk_run;
    wr_mcu  = 1'b0;
    wr_pr   = 1'b0;
    wd      = 8'h00;
    clk_run = 1'b0;
    s_next  = s_reg;
    wr_mcu  = wr_acc && hit(paddr, spr_pkg::MCU_PWR_ADDR);
    wr_pr   = wr_acc && hit(paddr, spr_pkg::PWR_RED_ADDR);
    wd      = pwdata[7:0];

    // unlock window and detector-off timers run down every cycle
    s_next.win      = dec_sat(s_reg.win);
    s_next.eff_cnt  = dec_sat(s_reg.eff_cnt);
    s_next.hold_cnt = dec_sat(s_reg.hold_cnt);
    if (s_reg.eff_cnt == 3'h1) begin
      s_next.det_eff = 1'b1;
    end
    if (s_reg.hold_cnt == 3'h1) begin
      s_next.mcu[spr_pkg::DET_OFF_BIT] = 1'b0;
      s_next.det_eff                   = 1'b0;
    end

    if (wr_mcu) begin
      s_next.mcu[spr_pkg::SLEEP_ARM_BIT]  = wd[spr_pkg::SLEEP_ARM_BIT];
      s_next.mcu[spr_pkg::SEL_HI_BIT]     = wd[spr_pkg::SEL_HI_BIT];
      s_next.mcu[spr_pkg::SEL_LO_BIT]     = wd[spr_pkg::SEL_LO_BIT];
      s_next.mcu[spr_pkg::DET_UNLOCK_BIT] = wd[spr_pkg::DET_UNLOCK_BIT];
      s_next.mcu = (s_next.mcu & ~spr_pkg::MCU_PLAIN_MASK) | (wd & spr_pkg::MCU_PLAIN_MASK);
      if (wd[spr_pkg::DET_OFF_BIT] && wd[spr_pkg::DET_UNLOCK_BIT]) begin
        // first step opens the window, detector-off itself stays put
        s_next.win = spr_pkg::UNLOCK_CYCLES;
      end else if (wd[spr_pkg::DET_OFF_BIT] && s_reg.win != 3'h0) begin
        s_next.mcu[spr_pkg::DET_OFF_BIT] = 1'b1;
        s_next.win      = 3'h0;
        s_next.eff_cnt  = spr_pkg::DET_DELAY_CYCLES;
        s_next.hold_cnt = spr_pkg::DET_HOLD_CYCLES + spr_pkg::DET_DELAY_CYCLES;
      end
      // a set outside the window changes nothing: bit keeps its value
    end

    // only the low four bits are writable; top bits come from elsewhere
    if (wr_pr) begin
      s_next.gate = wd[3:0] & spr_pkg::PWR_RED_WMASK[3:0];
    end

    // apb answer: ready one cycle after setup, data latched with it
    s_next.ready = setup;
    s_next.err   = setup && !hit(paddr, spr_pkg::MCU_PWR_ADDR) &&
                   !hit(paddr, spr_pkg::PWR_RED_ADDR);
    s_next.rdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      if (hit(paddr, spr_pkg::MCU_PWR_ADDR)) begin
        s_next.rdata = {24'h00_0000, s_reg.mcu};
      end else if (hit(paddr, spr_pkg::PWR_RED_ADDR)) begin
        s_next.rdata = {24'h00_0000, prep_read, 1'b0, s_reg.gate};
      end
    end
    if (rd_acc) begin
      s_next.rdata = s_reg.rdata;
    end

    // clock enables: sleep mode first, then per-peripheral gating
    clk_run = !fsm_asleep;
    s_next.clk.cpu        = clk_run;
    s_next.clk.flash      = clk_run;
    s_next.clk.io         = clk_run ||
                            (fsm_mode == spr_pkg::SPR_MODE_IDLE);
    s_next.clk.conv       = !s_reg.gate[spr_pkg::GATE_CONV_BIT] &&
                            (clk_run || fsm_mode != spr_pkg::SPR_MODE_PDOWN);
    s_next.clk.timer1     = s_next.clk.io && !s_reg.gate[spr_pkg::GATE_T1_BIT];
    s_next.clk.timer0     = s_next.clk.io && !s_reg.gate[spr_pkg::GATE_T0_BIT];
    s_next.clk.serial     = s_next.clk.io && !s_reg.gate[spr_pkg::GATE_SER_BIT];
    s_next.clk.async_only = fsm_asleep &&
                            (fsm_mode == spr_pkg::SPR_MODE_PDOWN);

    // a gated peripheral keeps its state and refuses register access
    s_next.acc.timer1 = !s_reg.gate[spr_pkg::GATE_T1_BIT];
    s_next.acc.timer0 = !s_reg.gate[spr_pkg::GATE_T0_BIT];
    s_next.acc.serial = !s_reg.gate[spr_pkg::GATE_SER_BIT];
    s_next.acc.conv   = !s_reg.gate[spr_pkg::GATE_CONV_BIT];
    s_next.mux_ok     = !s_reg.gate[spr_pkg::GATE_CONV_BIT];

    // detector off only while asleep with the bit in effect at entry
    s_next.det_dis = fsm_det_off;
    s_next.slp     = fsm_asleep;
    s_next.smode   = fsm_mode;
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg      <= '0;
      s_reg.mcu  <= spr_pkg::MCU_PWR_RST;
      s_reg.gate <= spr_pkg::PWR_RED_RST[3:0];
      s_reg.clk  <= '{cpu: 1'b1, io: 1'b1, flash: 1'b1, conv: 1'b1,
                      timer1: 1'b1, timer0: 1'b1, serial: 1'b1, async_only: 1'b0};
      s_reg.acc  <= '1;
      s_reg.mux_ok <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign prdata           = s_reg.rdata;
  assign pready           = s_reg.ready;
  assign pslverr          = s_reg.err;
  assign clk_en           = s_reg.clk;
  assign periph_access    = s_reg.acc;
  assign comp_mux_allow   = s_reg.mux_ok;
  assign detector_disable = s_reg.det_dis;
  assign sleeping         = s_reg.slp;
  assign sleep_mode       = s_reg.smode;

endmodule // spr_ctrl
`default_nettype wire

// file: logic/spr_pkg.sv
// Purpose: shared constants and carriers for the sleep / power reduction control
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   mcu_power_control printed offset 0x35 is not a multiple of four, so
//          every printed offset is an index and the byte address is four times it
`default_nettype none
package spr_pkg;
  localparam logic [7:0]  PWR_RED_IDX      = 8'h00;
  localparam logic [7:0]  MCU_PWR_IDX      = 8'h35;
  localparam logic [11:0] PWR_RED_ADDR     = {2'h0, PWR_RED_IDX, 2'h0};
  localparam logic [11:0] MCU_PWR_ADDR     = {2'h0, MCU_PWR_IDX, 2'h0};
  localparam logic [7:0]  PWR_RED_RST      = 8'h00;
  localparam logic [7:0]  MCU_PWR_RST      = 8'h00;
  // mcu_power_control field positions
  localparam int          DET_OFF_BIT      = 7;
  localparam int          SLEEP_ARM_BIT    = 5;
  localparam int          SEL_HI_BIT       = 4;
  localparam int          SEL_LO_BIT       = 3;
  localparam int          DET_UNLOCK_BIT   = 2;
  // bits kept as plain storage here (pull-up and sense bits belong elsewhere)
  localparam logic [7:0]  MCU_PLAIN_MASK   = 8'h43;
  // power_reduction field positions
  localparam int          GATE_T1_BIT      = 3;
  localparam int          GATE_T0_BIT      = 2;
  localparam int          GATE_SER_BIT     = 1;
  localparam int          GATE_CONV_BIT    = 0;
  localparam logic [7:0]  PWR_RED_WMASK    = 8'h0f;
  // timing, in system clock cycles
  localparam logic [2:0]  UNLOCK_CYCLES    = 3'h4;
  localparam logic [2:0]  DET_DELAY_CYCLES = 3'h3;
  localparam logic [2:0]  DET_HOLD_CYCLES  = 3'h3;

  typedef enum logic [1:0] {
    SPR_MODE_IDLE,
    SPR_MODE_NOISE,
    SPR_MODE_PDOWN,
    SPR_MODE_RSVD
  } spr_mode_t;

  // clock enables toward the rest of the chip
  typedef struct packed {
    logic cpu;
    logic io;
    logic flash;
    logic conv;
    logic timer1;
    logic timer0;
    logic serial;
    logic async_only;
  } spr_clk_en_t;

  // per-peripheral access permission for their own i/o registers
  typedef struct packed {
    logic timer1;
    logic timer0;
    logic serial;
    logic conv;
  } spr_access_t;
endpackage : spr_pkg
`default_nettype wire

// file: logic/spr_sleep_fsm.sv
// Purpose: sleep state tracking and detector shutdown during sleep
// Assumes: sleep_req is a one-cycle pulse from the core, wake a level
// Notes:   reserved mode code is treated as no sleep
`default_nettype none
module spr_sleep_fsm (
  input  wire logic              pclk,          // system clock
  input  wire logic              presetn,       // async reset, low
  input  wire logic              sleep_req,     // sleep instruction pulse
  input  wire logic              wake,          // wake-up event level
  input  wire logic              sleep_arm,     // arm bit
  input  wire logic [1:0]        sleep_sel,     // selected mode
  input  wire logic              det_active,    // detector-off bit in effect
  output logic                   asleep,        // core is sleeping
  output spr_pkg::spr_mode_t     mode,          // mode while asleep
  output logic                   det_off        // detector switched off
);

  typedef enum logic [1:0] { SPR_AWAKE, SPR_SLEEP } spr_slp_state_t;

  typedef struct packed {
    spr_slp_state_t     st;
    spr_pkg::spr_mode_t mode;
    logic               det_off;
  } spr_slp_t;

  spr_slp_t s_reg;
  spr_slp_t s_next;

  ////////////////////////////////////////////////////////////////////////
  // sleep entry only when armed and the code is not reserved
  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      SPR_AWAKE: begin
        if (sleep_req && sleep_arm &&
            spr_pkg::spr_mode_t'(sleep_sel) != spr_pkg::SPR_MODE_RSVD) begin
          s_next.st      = SPR_SLEEP;
          s_next.mode    = spr_pkg::spr_mode_t'(sleep_sel);
          s_next.det_off = det_active;
        end
      end
      SPR_SLEEP: begin
        if (wake) begin
          s_next.st      = SPR_AWAKE;
          s_next.det_off = 1'b0;
        end
      end
      default: s_next.st = SPR_AWAKE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{st: SPR_AWAKE, mode: spr_pkg::SPR_MODE_IDLE, det_off: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign asleep  = (s_reg.st == SPR_SLEEP);
  assign mode    = s_reg.mode;
  assign det_off = s_reg.det_off;

endmodule // spr_sleep_fsm
`default_nettype wire

// file: test/spr_core_model.sv
// Purpose: core side model, sleep instruction and wake source
// Assumes: one sleep pulse per request, wake held until awake
// Notes:   wake_dly makes the wake prompt or slow
`default_nettype none
module spr_core_model (
  input  wire logic       pclk,      // clock
  input  wire logic       presetn,   // reset, low
  input  wire logic       go_sleep,  // firmware reaches sleep
  input  wire logic       sleeping,  // core asleep
  input  wire logic [2:0] wake_dly,  // cycles before wake
  output var  logic       sleep_req, // sleep instruction
  output var  logic       wake       // wake event level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt; // cycles spent asleep
  // wake is held until the core is awake, never left floating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_req <= 1'b0;
      wake      <= 1'b0;
      cnt       <= 3'h0;
    end else begin
      sleep_req <= go_sleep;
      if (!sleeping) begin
        wake <= 1'b0;
        cnt  <= 3'h0;
      end else if (cnt == wake_dly) begin
        wake <= 1'b1;
      end else begin
        cnt <= cnt + 3'h1;
      end
    end
  end
endmodule // spr_core_model
`default_nettype wire

// file: test/spr_ctrl_chk.sv
// Purpose: concurrent checks on the sleep and power reduction control ports
// Assumes: zero-wait apb slave, registered clock enables
// Notes:   arm and select are shadowed from completed writes
`default_nettype none
module spr_ctrl_chk (
  input wire logic                 pclk,             // clock
  input wire logic                 presetn,          // reset, low
  input wire logic                 psel,             // apb select
  input wire logic                 penable,          // apb access
  input wire logic                 pwrite,           // apb direction
  input wire logic [11:0]          paddr,            // apb address
  input wire logic [31:0]          pwdata,           // apb write data
  input wire logic [31:0]          prdata,           // apb read data
  input wire logic                 pready,           // apb ready
  input wire logic                 pslverr,          // apb error
  input wire logic                 sleep_req,        // sleep pulse
  input wire spr_pkg::spr_clk_en_t clk_en,           // clock enables
  input wire logic                 comp_mux_allow,   // comparator mux
  input wire logic                 detector_disable, // detector off
  input wire logic                 sleeping,         // asleep
  input wire logic [1:0]           sleep_mode        // active mode
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////
  logic       acc;    // completed transfer
  logic       wr_red; // write landing in power_reduction
  logic       wr_mcu; // write landing in mcu_power_control
  logic       arm_q;  // shadow of the arm bit
  logic [1:0] sel_q;  // shadow of the select field
  assign acc    = psel && penable && pready;
  assign wr_red = acc && pwrite && paddr == spr_pkg::PWR_RED_ADDR;
  assign wr_mcu = acc && pwrite && paddr == spr_pkg::MCU_PWR_ADDR;
  // shadow updates on the same edge as the design register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_q <= 1'b0;
      sel_q <= 2'h0;
    end else if (wr_mcu) begin
      arm_q <= pwdata[5];
      sel_q <= pwdata[4:3];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  unmapped_err_a: assert property (acc && paddr != spr_pkg::PWR_RED_ADDR &&
    paddr != spr_pkg::MCU_PWR_ADDR |-> pslverr) else $error("no error on unmapped");
  red_read_zero_a: assert property (
    acc && !pwrite && paddr == spr_pkg::PWR_RED_ADDR |-> !prdata[4]) else $error("bit4 set");
  timer1_gate_a: assert property (
    wr_red && pwdata[3] |-> ##[1:2] !clk_en.timer1) else $error("timer1 not gated");
  timer0_run_a: assert property (
    wr_red && !pwdata[2] |-> ##[1:2] clk_en.timer0) else $error("timer0 not resumed");
  conv_mux_a: assert property (
    wr_red && pwdata[0] |-> ##[1:2] !comp_mux_allow) else $error("mux still allowed");
  arm_sleep_a: assert property (
    sleep_req && arm_q && sel_q != 2'h3 && !sleeping |-> ##2 sleeping) else $error("no sleep");
  sel_mode_a: assert property (
    sleeping [*2] |-> sleep_mode == sel_q) else $error("wrong sleep mode");
  noise_clk_a: assert property (
    sleeping [*3] ##0 sleep_mode == 2'h1 |-> !clk_en.cpu && !clk_en.io && clk_en.conv)
    else $error("noise clocks wrong");
  pdown_clk_a: assert property (
    sleeping [*3] ##0 sleep_mode == 2'h2 |-> !clk_en.cpu && !clk_en.io && !clk_en.timer1)
    else $error("power-down clocks run");
  det_sleep_a: assert property (
    detector_disable |-> sleeping || $past(sleeping)) else $error("detector off awake");
  // main scenarios reached
  cover property (sleeping && detector_disable);
  cover property (acc && pslverr);
  cover property (wr_red && pwdata[0]);
endmodule // spr_ctrl_chk
bind spr_ctrl spr_ctrl_chk u_spr_ctrl_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .clk_en(clk_en),
  .comp_mux_allow(comp_mux_allow), .detector_disable(detector_disable),
  .sleeping(sleeping), .sleep_mode(sleep_mode));
`default_nettype wire

// file: test/spr_ctrl_tb_top.sv
// Purpose: self-checking bench for the sleep and power reduction control
// Assumes: zero-wait apb, expectations queued by the driver
// Notes:   random gating values from an xorshift sequence
`default_nettype none
module spr_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] RED = spr_pkg::PWR_RED_ADDR;
  localparam logic [11:0] MCU = spr_pkg::MCU_PWR_ADDR;
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0;
  logic [2:0]           prep_read = 3'h5;
  logic                 go_sleep = 1'b0;
  logic [2:0]           wake_dly = 3'h7;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 sleep_req;
  logic                 wake;
  spr_pkg::spr_clk_en_t clk_en;
  spr_pkg::spr_access_t periph_access;
  logic                 comp_mux_allow;
  logic                 detector_disable;
  logic                 sleeping;
  logic [1:0]           sleep_mode;
  logic [32:0]          exp_q[$];
  logic [31:0]          rnd = 32'd74300;
  int                   error_cnt = 0;
  int                   n_compared = 0;
  int                   cyc = 0;
  always #20 pclk = ~pclk;
  spr_ctrl u_spr_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prep_read(prep_read), .sleep_req(sleep_req), .wake(wake),
    .clk_en(clk_en), .periph_access(periph_access), .comp_mux_allow(comp_mux_allow),
    .detector_disable(detector_disable), .sleeping(sleeping), .sleep_mode(sleep_mode));
  spr_core_model u_spr_core_model (.pclk(pclk), .presetn(presetn), .go_sleep(go_sleep),
    .sleeping(sleeping), .wake_dly(wake_dly), .sleep_req(sleep_req), .wake(wake));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // clock enables {cpu,io,flash,conv,timer1,timer0,serial,async_only}, no gates set
  function automatic logic [7:0] exp_clk(input logic s, input logic [1:0] md);
    if (!s) return 8'hfe;
    case (md)
      2'h0:    return 8'h5e;
      2'h1:    return 8'h10;
      default: return 8'h01;
    endcase
  endfunction
  // one apb transfer; a read notes its expected {pslverr, prdata}
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // sleep instruction, then the state a few cycles on and after the wake
  task automatic nap(input logic s, input logic [1:0] md, input logic d);
    go_sleep <= 1'b1;
    @(posedge pclk);
    go_sleep <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({21'h0, clk_en, sleeping, detector_disable, s ? sleep_mode : md},
        {21'h0, exp_clk(s, md), s, d, md});
    repeat (20) @(posedge pclk);
    chk({23'h0, clk_en, sleeping, detector_disable}, {23'h0, 8'hfe, 2'h0});
  endtask
  ////////////////////////////////////////////////////////////////////////
  // read results compared in completion order
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, RED, 32'h0, {25'h0, 3'h5, 5'h0});
    apb(1'b0, MCU, 32'h0, 33'h0);
    apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
    // random gating; converter assumed idle before its gate is set
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      prep_read <= rnd[10:8];
      apb(1'b1, RED, rnd, 33'h0);
      apb(1'b0, RED, 32'h0, {25'h0, rnd[10:8], 1'b0, rnd[3:0]});
      chk({24'h0, clk_en.timer1, clk_en.timer0, clk_en.serial, clk_en.conv, periph_access,
           comp_mux_allow}, {24'h0, ~rnd[3:0], ~rnd[3:0], ~rnd[0]});
    end
    // mid-run reset with gates set: enables and access back to reset values
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({20'h0, clk_en, periph_access, comp_mux_allow}, {20'h0, 8'hfe, 4'hf, 1'b1});
    presetn <= 1'b1;
    apb(1'b0, RED, 32'h0, {25'h0, rnd[10:8], 5'h0});
    apb(1'b0, MCU, 32'h0, 33'h0);
    apb(1'b1, RED, 32'h0, 33'h0);
    // unlock, then set on the last cycle of the window, then let it lapse
    apb(1'b1, MCU, 32'h84, 33'h0);
    repeat (1) @(posedge pclk);
    apb(1'b1, MCU, 32'h80, 33'h0);
    apb(1'b0, MCU, 32'h0, 33'h80);
    repeat (8) @(posedge pclk);
    apb(1'b0, MCU, 32'h0, 33'h0);
    // a set landing on the first cycle after the window has closed
    apb(1'b1, MCU, 32'h84, 33'h0);
    repeat (2) @(posedge pclk);
    apb(1'b1, MCU, 32'h80, 33'h0);
    apb(1'b0, MCU, 32'h0, 33'h0);
    // every select code with arm set, disarmed after each wake
    for (int m = 0; m < 4; m++) begin
      wake_dly <= 3'h4 + m[2:0];
      apb(1'b1, MCU, {26'h0, 1'b1, m[1:0], 3'h0}, 33'h0);
      nap(m != 3, m[1:0], 1'b0);
      apb(1'b1, MCU, 32'h0, 33'h0);
    end
    apb(1'b1, MCU, 32'h10, 33'h0);
    nap(1'b0, 2'h2, 1'b0);
    // power-down sleep at each lag after the set: only lags 2..4 meet it in effect
    wake_dly <= 3'h7;
    for (int k = 1; k < 6; k++) begin
      apb(1'b1, MCU, 32'hb4, 33'h0);
      apb(1'b1, MCU, 32'hb0, 33'h0);
      repeat (k) @(posedge pclk);
      nap(1'b1, 2'h2, k > 1 && k < 5);
      apb(1'b1, MCU, 32'h0, 33'h0);
    end
    end_sim();
  end
endmodule // spr_ctrl_tb_top
`default_nettype wire
